/* hdl/ldf_top.sv */
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Two-bit code per channel, 11 means ok
// - Newest detection overwrites the stored code
// - Overcurrent switches channel off, stores 10
// - Load codes stored only after filter delay
// - Open/short swap keeps timer, stores latest
// - Blind bit clear gives standard delay everywhere
// - Channels 7-10 get 2.5ms or 5ms delay
// - Extended delay also filters short to ground
// - Overcurrent channel stays off until cleared
// - Protection during code write is held
module ldf_top #(
    parameter int NUM_CH = ldf_pkg::NUM_CH,
    parameter int TICK_CYCLES = ldf_pkg::TICK_CYCLES,
    parameter int TD_STD_US = ldf_pkg::TD_MAX_US,
    parameter int TD_EXT1_US = ldf_pkg::TD_EXT1_TYP_US,
    parameter int TD_EXT2_US = ldf_pkg::TD_EXT2_TYP_US
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [NUM_CH-1:0] scg_det_in,
    input wire logic [NUM_CH-1:0] ol_det_in,
    input wire logic [NUM_CH-1:0] oct_det_in,
    input wire logic [NUM_CH-1:0] ch_on_in,
    output logic [NUM_CH-1:0] ch_drive_out,
    output logic irq_out,
    input wire logic [ldf_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ldf_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    localparam int DW = ldf_pkg::DLY_W;

    logic [15:0] tick_cnt;
    logic tick;
    logic aw_hold;
    logic w_hold;
    logic [ldf_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] ctrl;
    logic [NUM_CH-1:0] irq_status;
    logic [NUM_CH-1:0] irq_enable;
    logic [2*NUM_CH-1:0] codes;
    logic [NUM_CH-1:0] drive;
    logic [NUM_CH-1:0] fault_evt;
    logic [DW-1:0] dly_sel [NUM_CH];

    // One-microsecond enable for the filter timers
    wire tick_wrap = (tick_cnt == 16'(TICK_CYCLES - 1));
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? 16'h0 : tick_cnt + 16'h1;
            tick <= tick_wrap;
        end
    end

    wire bt_en = ctrl[ldf_pkg::CTRL_BT_EN_POS];
    wire bt_len = ctrl[ldf_pkg::CTRL_BT_LEN_POS];
    wire [NUM_CH-1:0] off_diag_en =
        ctrl[ldf_pkg::CTRL_OFF_DIAG_POS +: NUM_CH];

    // Write side of the register bus
    wire do_wr = aw_hold & w_hold & ~s_axi_bvalid_out;
    wire wr_ctrl = do_wr && aw_addr == ldf_pkg::OFF_CONTROL;
    wire wr_clear = do_wr && aw_addr == ldf_pkg::OFF_DIAG_CLEAR;
    wire wr_iclr = do_wr && aw_addr == ldf_pkg::OFF_IRQ_CLEAR;
    wire wr_ien = do_wr && aw_addr == ldf_pkg::OFF_IRQ_ENABLE;
    wire wr_ro = do_wr && (aw_addr == ldf_pkg::OFF_FAULT_CODES ||
        aw_addr == ldf_pkg::OFF_IRQ_STATUS);
    wire wr_ok = wr_ctrl | wr_clear | wr_iclr | wr_ien | wr_ro;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
        {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] ctrl_wm = wmask & ldf_pkg::CTRL_MASK;
    wire [NUM_CH-1:0] clear_vec =
        wr_clear ? w_data[NUM_CH-1:0] : '0;
    wire [NUM_CH-1:0] iclr_vec = wr_iclr ? w_data[NUM_CH-1:0] : '0;

    assign s_axi_awready_out = ~aw_hold & ~s_axi_bvalid_out;
    assign s_axi_wready_out = ~w_hold & ~s_axi_bvalid_out;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= ldf_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            if (do_wr) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_ok ? ldf_pkg::RESP_OKAY
                                         : ldf_pkg::RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl <= ldf_pkg::CTRL_RST;
            irq_enable <= NUM_CH'(ldf_pkg::IRQ_ENABLE_RST);
            irq_status <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= (ctrl & ~ctrl_wm) | (w_data & ctrl_wm);
            end
            if (wr_ien) begin
                irq_enable <= w_data[NUM_CH-1:0];
            end
            irq_status <= (irq_status & ~iclr_vec) | fault_evt;
        end
    end

    assign irq_out = |(irq_status & irq_enable);

    // Read side of the register bus
    wire [ldf_pkg::ADDR_W-1:0] ra = s_axi_araddr_in;
    wire rd_codes = ra == ldf_pkg::OFF_FAULT_CODES;
    wire rd_ctrl = ra == ldf_pkg::OFF_CONTROL;
    wire rd_stat = ra == ldf_pkg::OFF_IRQ_STATUS;
    wire rd_ien = ra == ldf_pkg::OFF_IRQ_ENABLE;
    wire rd_wo = ra == ldf_pkg::OFF_DIAG_CLEAR ||
        ra == ldf_pkg::OFF_IRQ_CLEAR;
    wire rd_ok = rd_codes | rd_ctrl | rd_stat | rd_ien | rd_wo;
    wire [31:0] rd_val =
        rd_codes ? 32'(codes) :
        rd_ctrl ? ctrl :
        rd_stat ? 32'(irq_status) :
        rd_ien ? 32'(irq_enable) : 32'h0;

    assign s_axi_arready_out = ~s_axi_rvalid_out;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= ldf_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_val;
            s_axi_rresp_out <= rd_ok ? ldf_pkg::RESP_OKAY
                                     : ldf_pkg::RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        ldf_chan_if u_if ();
        // Blind time extension only for the upper channel group
        assign dly_sel[i] = (bt_en && i >= ldf_pkg::EXT_FIRST_CH) ?
            (bt_len ? DW'(TD_EXT2_US) : DW'(TD_EXT1_US)) :
            DW'(TD_STD_US);
        assign u_if.short_to_ground_code = scg_det_in[i];
        assign u_if.ol = ol_det_in[i];
        assign u_if.overcurrent_overtemp_code = oct_det_in[i];
        assign u_if.on_req = ch_on_in[i];
        assign u_if.off_diag_en = off_diag_en[i];
        assign u_if.clear = clear_vec[i];
        assign u_if.tick = tick;
        assign u_if.delay = dly_sel[i];
        assign codes[2*i +: 2] = u_if.code;
        assign drive[i] = u_if.drive;
        assign fault_evt[i] = u_if.fault_evt;
        ldf_chan_filter u_ch (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .ch(u_if.chan)
        );
        drive_off_a: assert property (
            @(posedge clk_in) disable iff (!nrst_in)
            oct_det_in[i] |=> !ch_drive_out[i])
            else $error("Overcurrent channel still driven");
        latch_hold_a: assert property (
            @(posedge clk_in) disable iff (!nrst_in)
            !ch_drive_out[i] && codes[2*i +: 2] == ldf_pkg::CODE_OCT &&
                !clear_vec[i] |=> !ch_drive_out[i])
            else $error("Latched channel on without clear");
    end

    assign ch_drive_out = drive;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    std_delay_a: assert property (
        !bt_en |-> dly_sel[NUM_CH-1] == DW'(TD_STD_US) &&
            dly_sel[0] == DW'(TD_STD_US))
        else $error("Standard delay not applied");
    ext_delay_a: assert property (
        bt_en && bt_len |-> dly_sel[NUM_CH-1] == DW'(TD_EXT2_US) &&
            dly_sel[0] == DW'(TD_STD_US))
        else $error("Extended delay wrong");
    irq_set_a: assert property (
        fault_evt[0] |=> irq_status[0])
        else $error("Fault event lost from status");
    bresp_hold_a: assert property (
        s_axi_bvalid_out && !s_axi_bready_in |=>
            s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("Write response dropped before taken");
    clear_path_a: assert property (
        wr_clear && w_data[0] |=> codes[1:0] == ldf_pkg::CODE_OK)
        else $error("Clear command not applied");

    // Delay selection and clear checks
    ext1_delay_a: assert property (
        bt_en && !bt_len |->
            dly_sel[ldf_pkg::EXT_FIRST_CH] == DW'(TD_EXT1_US) &&
            dly_sel[NUM_CH-1] == DW'(TD_EXT1_US))
        else $error("First extended delay wrong");
    low_group_a: assert property (
        bt_en |-> dly_sel[ldf_pkg::EXT_FIRST_CH-1] == DW'(TD_STD_US))
        else $error("Extension reached a lower channel");
    clear_last_a: assert property (
        clear_vec[NUM_CH-1] |=> codes[2*NUM_CH-2 +: 2] == ldf_pkg::CODE_OK)
        else $error("Clear missed the last channel");

    // Register bus protocol checks
    wr_answer_a: assert property (
        do_wr |=> s_axi_bvalid_out)
        else $error("Write response missing");
    wr_error_a: assert property (
        do_wr && !wr_ok |=> s_axi_bresp_out == ldf_pkg::RESP_SLVERR)
        else $error("Unmapped write not refused");
    ro_write_a: assert property (
        wr_ro |=> $stable(ctrl) && $stable(irq_enable))
        else $error("Read-only write changed a register");
    ctrl_write_a: assert property (
        wr_ctrl && w_strb == 4'hf |=>
            ctrl == ($past(w_data) & ldf_pkg::CTRL_MASK))
        else $error("Control write not applied");
    ien_write_a: assert property (
        wr_ien |=> irq_enable == $past(w_data[NUM_CH-1:0]))
        else $error("Enable write not applied");
    bresp_done_a: assert property (
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
        else $error("Write response not retired");
    rd_answer_a: assert property (
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("Read response missing");
    rd_error_a: assert property (
        s_axi_arvalid_in && s_axi_arready_out && !rd_ok |=>
            s_axi_rresp_out == ldf_pkg::RESP_SLVERR && s_axi_rdata_out == '0)
        else $error("Unmapped read not refused");
    codes_read_a: assert property (
        s_axi_arvalid_in && s_axi_arready_out && rd_codes |=>
            s_axi_rdata_out == 32'($past(codes)))
        else $error("Fault codes read wrong");
    rdata_hold_a: assert property (
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
            $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
        else $error("Read data dropped before taken");
    rvalid_done_a: assert property (
        s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("Read response not retired");

    // Interrupt and divider checks
    irq_clear_a: assert property (
        wr_iclr && w_data[0] && !fault_evt[0] |=> !irq_status[0])
        else $error("Status bit not cleared");
    status_keep_a: assert property (
        irq_status[0] && !(wr_iclr && w_data[0]) |=> irq_status[0])
        else $error("Status bit dropped without clear");
    tick_phase_a: assert property (
        tick |-> tick_cnt == 16'h0)
        else $error("Filter tick out of phase");
    wr_c: cover property (do_wr && wr_clear);
    irq_c: cover property ($rose(irq_out));
endmodule

/* shared/ldf_pkg.sv */
package ldf_pkg;
    localparam int NUM_CH = 10;
    localparam int EXT_FIRST_CH = 6;
    localparam int DLY_W = 16;
    localparam int ADDR_W = 8;

    localparam logic [1:0] CODE_SCG = 2'h0;
    localparam logic [1:0] CODE_OL = 2'h1;
    localparam logic [1:0] CODE_OCT = 2'h2;
    localparam logic [1:0] CODE_OK = 2'h3;

    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    localparam int TICK_CYCLES = NS_PER_US / CLK_PERIOD_NS;
    localparam int TD_MIN_US = 100;
    localparam int TD_MAX_US = 220;
    localparam int TD_EXT1_TYP_US = 2500;
    localparam int TD_EXT1_MAX_US = 3450;
    localparam int TD_EXT2_TYP_US = 5000;
    localparam int TD_EXT2_MAX_US = 7300;

    localparam logic [ADDR_W-1:0] OFF_FAULT_CODES = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DIAG_CLEAR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h14;

    localparam int CTRL_BT_EN_POS = 0;
    localparam int CTRL_BT_LEN_POS = 1;
    localparam int CTRL_OFF_DIAG_POS = 8;
    localparam logic [31:0] CTRL_MASK = 32'h0003ff03;
    localparam logic [31:0] CTRL_RST = 32'h0003ff00;
    localparam logic [31:0] IRQ_ENABLE_RST = 32'h00000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* shared/ldf_chan_if.sv */
`timescale 1ns/1ps
interface ldf_chan_if;
    logic short_to_ground_code;
    logic ol;
    logic overcurrent_overtemp_code;
    logic on_req;
    logic off_diag_en;
    logic clear;
    logic tick;
    logic [ldf_pkg::DLY_W-1:0] delay;
    logic [1:0] code;
    logic drive;
    logic fault_evt;
    modport ctrl (output short_to_ground_code, ol, overcurrent_overtemp_code, on_req, off_diag_en, clear, tick,
                  delay, input code, drive, fault_evt);
    modport chan (input short_to_ground_code, ol, overcurrent_overtemp_code, on_req, off_diag_en, clear, tick,
                  delay, output code, drive, fault_evt);
endinterface

/* hdl/ldf_chan_filter.sv */
`timescale 1ns/1ps
module ldf_chan_filter (
    input wire logic clk_in,
    input wire logic nrst_in,
    ldf_chan_if.chan ch
);
    logic [1:0] code;
    logic [1:0] next_code;
    logic [ldf_pkg::DLY_W-1:0] cnt;
    logic pend_oct;
    logic latched;
    logic drive;
    logic evt;

    // Load conditions are filtered only while off diagnosis is enabled
    wire act = ch.off_diag_en & (ch.short_to_ground_code | ch.ol);
    wire [1:0] latest = ch.short_to_ground_code ? ldf_pkg::CODE_SCG : ldf_pkg::CODE_OL;
    wire expire = act & ch.tick &
        (cnt == ch.delay - ldf_pkg::DLY_W'(1));
    wire oct_now = ch.overcurrent_overtemp_code | pend_oct;
    wire next_latched = ch.clear ? 1'b0 : (latched | oct_now);
    wire next_pend = ch.clear ? ch.overcurrent_overtemp_code : (expire & oct_now);

    always_comb begin
        if (ch.clear) begin
            next_code = ldf_pkg::CODE_OK;
        end else if (expire) begin
            next_code = latest;
        end else if (oct_now) begin
            next_code = ldf_pkg::CODE_OCT;
        end else begin
            next_code = code;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            code <= ldf_pkg::CODE_OK;
            cnt <= '0;
            pend_oct <= 1'b0;
            latched <= 1'b0;
            drive <= 1'b0;
            evt <= 1'b0;
        end else begin
            code <= next_code;
            pend_oct <= next_pend;
            latched <= next_latched;
            drive <= ch.on_req & ~next_latched & ~ch.overcurrent_overtemp_code;
            evt <= (next_code != code) && (next_code != ldf_pkg::CODE_OK);
            if (!act || ch.clear || expire) begin
                cnt <= '0;
            end else if (ch.tick) begin
                cnt <= cnt + ldf_pkg::DLY_W'(1);
            end
        end
    end

    assign ch.code = code;
    assign ch.drive = drive;
    assign ch.fault_evt = evt;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    oct_switch_off_a: assert property (
        ch.overcurrent_overtemp_code && !ch.clear |=> !drive &&
            (code == ldf_pkg::CODE_OCT || pend_oct))
        else $error("Overcurrent did not switch channel off");
    latch_release_a: assert property (
        $fell(latched) |-> $past(ch.clear))
        else $error("Latched channel released without clear");
    latched_off_a: assert property (
        latched |-> !drive)
        else $error("Latched channel is driven");
    filter_store_a: assert property (
        $changed(code) && (code == ldf_pkg::CODE_OL ||
            code == ldf_pkg::CODE_SCG)
        |-> $past(ch.tick) && $past(cnt) == $past(ch.delay) - 16'h1)
        else $error("Load code stored before filter expiry");
    no_restart_a: assert property (
        act && !ch.clear && ch.tick && !expire ##1 act && !ch.clear
        |-> cnt == $past(cnt) + 16'h1)
        else $error("Filter timer restarted on condition change");
    held_event_a: assert property (
        pend_oct && !ch.clear |=> code == ldf_pkg::CODE_OCT)
        else $error("Held protection event not stored");
    clear_ok_a: assert property (
        ch.clear |=> code == ldf_pkg::CODE_OK && cnt == '0)
        else $error("Clear did not restore no fault");
    oct_seen_c: cover property (ch.overcurrent_overtemp_code ##1 code == ldf_pkg::CODE_OCT);
    ol_store_c: cover property (expire && latest == ldf_pkg::CODE_OL);
    held_c: cover property (expire && ch.overcurrent_overtemp_code);
endmodule

/* verification/ldf_host_model.sv */
`timescale 1ns/1ps
module ldf_host_model (
    input wire logic clk_in,
    output logic [ldf_pkg::ADDR_W-1:0] awaddr_out,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [31:0] wdata_out,
    output logic wvalid_out,
    input wire logic wready_in,
    input wire logic [1:0] bresp_in,
    input wire logic bvalid_in,
    output logic bready_out,
    output logic [ldf_pkg::ADDR_W-1:0] araddr_out,
    output logic arvalid_out,
    input wire logic arready_in,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in,
    input wire logic rvalid_in,
    output logic rready_out
);
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out} = '0;
    end
    // Released payload shows the inverse, never the stale value
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_in);
        awaddr_out <= a;
        wdata_out <= d;
        awvalid_out <= 1'b1;
        wvalid_out <= 1'b1;
        bready_out <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awvalid_out && awready_in) begin
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
            end
            if (wvalid_out && wready_in) begin
                wvalid_out <= 1'b0;
                wdata_out <= ~d;
            end
        end while (!bvalid_in);
        r = bresp_in;
        bready_out <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_in);
        araddr_out <= a;
        arvalid_out <= 1'b1;
        rready_out <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arvalid_out && arready_in) begin
                arvalid_out <= 1'b0;
                araddr_out <= ~a;
            end
        end while (!rvalid_in);
        d = rdata_in;
        r = rresp_in;
        rready_out <= 1'b0;
    endtask
endmodule

/* verification/load_diagnosis_filter_tb.sv */
`timescale 1ns/1ps
module load_diagnosis_filter_tb;
    logic clk_in, nrst_in, irq;
    logic [9:0] short_to_ground_code, ol, overcurrent_overtemp_code, on, drive;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [19:0] ec;
    int n_mismatch = 0;
    int total_checks = 0;
    ldf_top #(.TICK_CYCLES(2), .TD_STD_US(3), .TD_EXT1_US(12),
        .TD_EXT2_US(24)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .scg_det_in(short_to_ground_code), .ol_det_in(ol), .oct_det_in(overcurrent_overtemp_code), .ch_on_in(on),
        .ch_drive_out(drive), .irq_out(irq), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
    ldf_host_model host (.clk_in(clk_in), .awaddr_out(awaddr),
        .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata),
        .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
        .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
        .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
        .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input string n, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        check(n, d, e);
        check({n, " resp"}, {30'h0, r}, {30'h0, er});
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        check("bresp", {30'h0, r}, {30'h0, ldf_pkg::RESP_OKAY});
    endtask
    task automatic codes(input string n);
        rc(n, ldf_pkg::OFF_FAULT_CODES, {12'h0, ec}, ldf_pkg::RESP_OKAY);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        results();
    end
    initial begin
        {nrst_in, short_to_ground_code, ol, overcurrent_overtemp_code, on} = '0;
        ec = 20'hfffff;
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        codes("reset codes");
        rc("control", ldf_pkg::OFF_CONTROL, ldf_pkg::CTRL_RST, 2'h0);
        rc("irq enable", ldf_pkg::OFF_IRQ_ENABLE, 32'h0, 2'h0);
        rc("unmapped", 8'h40, 32'h0, ldf_pkg::RESP_SLVERR);
        $display("test reset done");
        w(ldf_pkg::OFF_CONTROL, ldf_pkg::CTRL_RST | 32'h1);
        ol <= 10'h061;
        repeat (8) @(posedge clk_in);
        ec[1:0] = ldf_pkg::CODE_OL;
        ec[11:10] = ldf_pkg::CODE_OL;
        codes("std delay");
        repeat (20) @(posedge clk_in);
        ec[13:12] = ldf_pkg::CODE_OL;
        codes("ext1 delay");
        codes("ol confirmed");
        ol <= 10'h000;
        $display("test delay done");
        w(ldf_pkg::OFF_CONTROL, ldf_pkg::CTRL_RST | 32'h3);
        ol <= 10'h002;
        short_to_ground_code <= 10'h081;
        @(posedge clk_in);
        ol <= 10'h000;
        short_to_ground_code <= 10'h083;
        repeat (10) @(posedge clk_in);
        ec[1:0] = ldf_pkg::CODE_SCG;
        ec[3:2] = ldf_pkg::CODE_SCG;
        codes("swap and overwrite");
        repeat (20) @(posedge clk_in);
        codes("ext2 not yet");
        repeat (30) @(posedge clk_in);
        ec[15:14] = ldf_pkg::CODE_SCG;
        codes("ext2 scg");
        short_to_ground_code <= 10'h000;
        $display("test swap done");
        check("irq masked", {31'h0, irq}, 32'h0);
        w(ldf_pkg::OFF_IRQ_CLEAR, 32'h3ff);
        rc("irq cleared", ldf_pkg::OFF_IRQ_STATUS, 32'h0, 2'h0);
        w(ldf_pkg::OFF_IRQ_ENABLE, 32'h004);
        on <= 10'h004;
        repeat (2) @(posedge clk_in);
        check("drive on", {22'h0, drive}, 32'h004);
        overcurrent_overtemp_code <= 10'h004;
        @(posedge clk_in);
        overcurrent_overtemp_code <= 10'h000;
        repeat (3) @(posedge clk_in);
        check("drive latched", {22'h0, drive}, 32'h0);
        check("irq raised", {31'h0, irq}, 32'h1);
        ec[5:4] = ldf_pkg::CODE_OCT;
        codes("oct code");
        w(ldf_pkg::OFF_CONTROL, 32'h0003fb00);
        w(ldf_pkg::OFF_DIAG_CLEAR, 32'h004);
        repeat (3) @(posedge clk_in);
        check("drive restored", {22'h0, drive}, 32'h004);
        ec[5:4] = ldf_pkg::CODE_OK;
        codes("cleared code");
        w(ldf_pkg::OFF_IRQ_CLEAR, 32'h004);
        check("irq dropped", {31'h0, irq}, 32'h0);
        w(ldf_pkg::OFF_CONTROL, ldf_pkg::CTRL_RST);
        $display("test overcurrent done");
        results();
    end
endmodule
